// File: hdl/nbf_target.sv
// Purpose: target-side engine of a flash on a 4-bit multiplexed bus
// Assumes: bus pins sampled on mclk; init_n is the second reset pin
// Notes: the array is a small model memory of ARRAY_WORDS bytes
// Function
// - nibbles are captured from the bus on every rising clock edge
// - a frame strobe with valid start code begins a cycle
// - start 1101 reads, 1110 writes, upper two bits set
// - clock 2 select nibble must equal the strap pins
// - address bits 19..0 pick the byte; 27..23, 21..20 ignored
// - bit 22 one selects array, zero selects register space
// - clock 10 size nibble 0000 means one byte
// - host drives 1111 then releases; device drives the next clock
// - read: device drives ready code 0000 in clock 13
// - read: byte returned in clocks 14 and 15, low nibble first
// - device drives 1111 one clock after its last nibble, then floats
// - write: host drives 1111 in 13 and releases in 14; device drives ready 0000 in clock 15
// - strobe mid-cycle ends it; bus released after abort nibble 1111
// - aborting a status read leaves program or erase running
// - only reset or init stops program or erase
// - id entry, program, sector and block erase accepted, no chip erase
// - program busy reads complement bit 7; erase reads 0 then 1
// - bit 6 toggles on every read while busy
// - reset or init returns to standby, floats bus, aborts operation
`timescale 1ns/1ns
`default_nettype none
module nbf_target
    import nbf_pkg::*;
#(
    parameter int ARRAY_WORDS = 256,
    parameter int PROGRAM_LOAD = PROGRAM_CYCLES,
    parameter int ERASE_LOAD = ERASE_CYCLES,
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] PART_CODE = 8'hA5
) (
    // clock and resets
    input wire logic mclk,
    input wire logic nrst,
    input wire logic init_n,
    // bus pins
    input wire logic frame_strobe_n,
    input wire logic [3:0] nibble_bus_in,
    output logic [3:0] nibble_bus_out,
    output logic nibble_bus_oe,
    // straps
    input wire logic [3:0] select_strap_pins,
    // status
    output logic op_busy,
    output logic reg_access
);
    localparam int AW = $clog2(ARRAY_WORDS);
    localparam int TW = 21;

    nbf_state_t state;
    logic is_write;
    logic [ADDR_BITS-1:0] address_field;
    logic [2:0] addr_idx;
    logic [7:0] wdata;
    logic half;
    logic turn_cnt;
    logic [7:0] mem [ARRAY_WORDS];
    logic [7:0] last_data;
    logic [7:0] read_byte;
    logic [7:0] stored;
    logic [2:0] unlock_step;
    logic id_mode;
    logic erasing;
    logic busy;
    logic done;
    logic op_start;
    logic [TW-1:0] op_load;
    logic write_commit;
    logic read_done;
    logic kill;
    logic frame;
    logic [AW-1:0] byte_idx;

    assign kill = !init_n;
    assign frame = !frame_strobe_n;
    assign byte_idx = address_field[AW-1:0];
    assign write_commit = (state == NBF_SYNC) && is_write;
    assign read_done = (state == NBF_RDATA) && half;

    always_ff @(posedge mclk) begin
        if (!nrst || kill) begin
            state <= NBF_IDLE;
            is_write <= 1'b0;
            addr_idx <= '0;
            half <= 1'b0;
            turn_cnt <= 1'b0;
        end else if (frame && state != NBF_IDLE && state != NBF_SELECT) begin
            state <= (nibble_bus_in == ABORT_NIBBLE) ? NBF_IDLE : NBF_ABORT;
        end else if (frame) begin
            if (nibble_bus_in == START_READ || nibble_bus_in == START_WRITE) begin
                state <= NBF_SELECT;
                is_write <= (nibble_bus_in == START_WRITE);
            end else begin
                state <= NBF_IDLE;
            end
        end else begin
            case (state)
                NBF_IDLE: state <= NBF_IDLE;
                NBF_SELECT: begin
                    addr_idx <= '0;
                    state <= (nibble_bus_in == select_strap_pins) ? NBF_ADDR : NBF_IDLE;
                end
                NBF_ADDR: begin
                    addr_idx <= addr_idx + 3'h1;
                    if (addr_idx == ADDR_LAST_IDX) begin
                        state <= NBF_SIZE;
                    end
                end
                NBF_SIZE: begin
                    half <= 1'b0;
                    turn_cnt <= 1'b0;
                    if (nibble_bus_in != SIZE_ONE_BYTE) begin
                        state <= NBF_IDLE;
                    end else begin
                        state <= is_write ? NBF_WDATA : NBF_TURN;
                    end
                end
                NBF_WDATA: begin
                    half <= ~half;
                    if (half) begin
                        state <= NBF_TURN;
                    end
                end
                NBF_TURN: state <= NBF_GRAB;
                NBF_GRAB: begin
                    half <= 1'b0;
                    state <= NBF_SYNC;
                end
                NBF_SYNC: state <= is_write ? NBF_RELEASE : NBF_RDATA;
                NBF_RDATA: begin
                    half <= ~half;
                    if (half) begin
                        state <= NBF_RELEASE;
                    end
                end
                NBF_RELEASE: state <= NBF_IDLE;
                NBF_ABORT: begin
                    if (nibble_bus_in == ABORT_NIBBLE) begin
                        state <= NBF_IDLE;
                    end
                end
                default: state <= NBF_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            address_field <= '0;
            wdata <= '0;
        end else if (state == NBF_ADDR) begin
            address_field <= {address_field[ADDR_BITS-5:0], nibble_bus_in};
        end else if (state == NBF_WDATA) begin
            // low nibble arrives first
            if (half) begin
                wdata[7:4] <= nibble_bus_in;
            end else begin
                wdata[3:0] <= nibble_bus_in;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || kill) begin
            nibble_bus_oe <= 1'b0;
            nibble_bus_out <= TURN_NIBBLE;
        end else if (frame && state != NBF_IDLE && state != NBF_SELECT) begin
            // a cut cycle keeps its drive until the abort nibble
            nibble_bus_oe <= nibble_bus_oe && (nibble_bus_in != ABORT_NIBBLE);
        end else if (frame) begin
            // drivers off on every strobe seen in idle or select
            nibble_bus_oe <= 1'b0;
            nibble_bus_out <= TURN_NIBBLE;
        end else begin
            case (state)
                NBF_TURN: begin
                    nibble_bus_oe <= 1'b0;
                    nibble_bus_out <= TURN_NIBBLE;
                end
                NBF_GRAB: begin
                    nibble_bus_oe <= 1'b1;
                    nibble_bus_out <= SYNC_READY;
                end
                NBF_SYNC: begin
                    nibble_bus_oe <= 1'b1;
                    nibble_bus_out <= is_write ? TURN_NIBBLE : read_byte[3:0];
                end
                NBF_RDATA: begin
                    nibble_bus_oe <= 1'b1;
                    nibble_bus_out <= half ? TURN_NIBBLE : read_byte[7:4];
                end
                NBF_ABORT: begin
                    // hold drive until abort nibble seen
                    nibble_bus_oe <= nibble_bus_oe && (nibble_bus_in != ABORT_NIBBLE);
                    nibble_bus_out <= nibble_bus_out;
                end
                default: begin
                    nibble_bus_oe <= 1'b0;
                    nibble_bus_out <= TURN_NIBBLE;
                end
            endcase
        end
    end

    always_comb begin
        if (!address_field[ARRAY_SELECT_BIT]) begin
            stored = '0;
        end else if (id_mode) begin
            stored = address_field[0] ? PART_CODE : MAKER_CODE;
        end else begin
            stored = mem[byte_idx];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || kill) begin
            unlock_step <= '0;
            id_mode <= 1'b0;
            op_start <= 1'b0;
            op_load <= '0;
            erasing <= 1'b0;
            last_data <= ERASED_BYTE;
        end else begin
            op_start <= 1'b0;
            if (write_commit && address_field[ARRAY_SELECT_BIT] && !busy) begin
                case (unlock_step)
                    3'h0, 3'h3: begin
                        unlock_step <= (address_field[15:0] == UNLOCK_ADDR_A && wdata == UNLOCK_DATA_A)
                            ? unlock_step + 3'h1 : 3'h0;
                        if (wdata == CMD_ID_EXIT) begin
                            id_mode <= 1'b0;
                        end
                    end
                    3'h1, 3'h4: begin
                        unlock_step <= (address_field[15:0] == UNLOCK_ADDR_B && wdata == UNLOCK_DATA_B)
                            ? unlock_step + 3'h1 : 3'h0;
                    end
                    3'h2: begin
                        unlock_step <= 3'h0;
                        if (address_field[15:0] == UNLOCK_ADDR_A) begin
                            if (wdata == CMD_PROGRAM) begin
                                unlock_step <= 3'h6;
                            end else if (wdata == CMD_ERASE_SETUP) begin
                                unlock_step <= 3'h3;
                            end else if (wdata == CMD_ID_ENTRY) begin
                                id_mode <= 1'b1;
                            end else if (wdata == CMD_ID_EXIT) begin
                                id_mode <= 1'b0;
                            end
                        end
                    end
                    3'h5: begin
                        // chip erase code falls through as invalid
                        unlock_step <= 3'h0;
                        if (wdata == CMD_SECTOR_ERASE || wdata == CMD_BLOCK_ERASE) begin
                            op_start <= 1'b1;
                            op_load <= TW'(ERASE_LOAD);
                            erasing <= 1'b1;
                        end
                    end
                    3'h6: begin
                        unlock_step <= 3'h0;
                        op_start <= 1'b1;
                        op_load <= TW'(PROGRAM_LOAD);
                        erasing <= 1'b0;
                        last_data <= wdata;
                    end
                    default: unlock_step <= 3'h0;
                endcase
            end
        end
    end

    // model array: program clears bits, erase sets the whole model to ones
    always_ff @(posedge mclk) begin
        if (op_start && !erasing && !busy) begin
            mem[byte_idx] <= mem[byte_idx] & last_data;
        end else if (done && erasing) begin
            for (int i = 0; i < ARRAY_WORDS; i++) begin
                mem[i] <= ERASED_BYTE;
            end
        end
    end

    nbf_busy_timer #(
        .WIDTH(TW)
    ) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .kill(kill),
        .start(op_start),
        .load(op_load),
        .busy(busy),
        .done(done)
    );

    nbf_status_byte u_status (
        .mclk(mclk),
        .nrst(nrst),
        .busy(busy),
        .erasing(erasing),
        .last_data(last_data),
        .read_done(read_done),
        .stored(stored),
        .read_byte(read_byte)
    );

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            op_busy <= 1'b0;
            reg_access <= 1'b0;
        end else begin
            op_busy <= busy;
            reg_access <= (state == NBF_SIZE) && !address_field[ARRAY_SELECT_BIT];
        end
    end

    // ready code follows size by three clocks on reads
    sequence rd_req_s;
        state == NBF_SIZE && !is_write && nibble_bus_in == SIZE_ONE_BYTE && !frame;
    endsequence
    sequence clean_s;
        !frame [*3];
    endsequence
    property rd_sync_p;
        @(posedge mclk) disable iff (!nrst || kill)
        rd_req_s ##1 clean_s |-> ##0 nibble_bus_oe && nibble_bus_out == SYNC_READY;
    endproperty
    read_sync_code_a: assert property (rd_sync_p) else $error("read sync missing");
    turn_float_a: assert property (@(posedge mclk) disable iff (!nrst)
        state == NBF_TURN |=> !nibble_bus_oe) else $error("drove during turnaround");
    read_data_order_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        state == NBF_SYNC && !is_write && !frame ##1 !frame |=> nibble_bus_out == $past(read_byte[7:4]))
        else $error("read nibble order");
    release_float_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        state == NBF_RELEASE && !frame |-> nibble_bus_out == TURN_NIBBLE && nibble_bus_oe ##1 !nibble_bus_oe)
        else $error("release turnaround");
    select_miss_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        state == NBF_SELECT && !frame && nibble_bus_in != select_strap_pins |=> state == NBF_IDLE ##1 !nibble_bus_oe)
        else $error("unselected cycle");
    bad_start_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        frame && state == NBF_IDLE && nibble_bus_in[3:2] != START_MARK |=> state == NBF_IDLE)
        else $error("bad start accepted");
    abort_busy_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        busy && frame && state != NBF_IDLE && !done |=> busy || done)
        else $error("abort stopped operation");
    init_float_a: assert property (@(posedge mclk) disable iff (!nrst)
        kill |=> !nibble_bus_oe && state == NBF_IDLE && !busy) else $error("init not honoured");
    toggle_flip_a: assert property (@(posedge mclk) disable iff (!nrst || kill)
        busy && read_done ##1 busy |-> read_byte[6] != $past(read_byte[6]))
        else $error("toggle bit stuck");
endmodule : nbf_target
`default_nettype wire

// File: hdl/nbf_pkg.sv
// Purpose: constants for the nibble bus flash target
// Assumes: single 20 MHz clock, inputs synchronous to it
// Notes: codes and field counts shared by the target, host and bench
package nbf_pkg;
    localparam logic [3:0] START_READ = 4'hD;
    localparam logic [3:0] START_WRITE = 4'hE;
    localparam logic [1:0] START_MARK = 2'h3;
    localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
    localparam logic [3:0] TURN_NIBBLE = 4'hF;
    localparam logic [3:0] SYNC_READY = 4'h0;
    localparam logic [3:0] ABORT_NIBBLE = 4'hF;
    localparam int ADDR_NIBBLES = 7;
    localparam int ADDR_BITS = 28;
    localparam int BYTE_ADDR_BITS = 20;
    localparam int ARRAY_SELECT_BIT = 22;
    localparam logic [2:0] ADDR_LAST_IDX = 3'h6;
    // unlock sequence addresses and data (low 16 address bits)
    localparam logic [15:0] UNLOCK_ADDR_A = 16'h5555;
    localparam logic [15:0] UNLOCK_ADDR_B = 16'h2AAA;
    localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // operation timing
    localparam int CLK_MHZ = 20;
    localparam int PROGRAM_TIME_US = 18;
    localparam int ERASE_TIME_MS = 70;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
    typedef enum logic [10:0] {
        NBF_IDLE   = 11'h001,
        NBF_SELECT = 11'h002,
        NBF_ADDR   = 11'h004,
        NBF_SIZE   = 11'h008,
        NBF_WDATA  = 11'h010,
        NBF_TURN   = 11'h020,
        NBF_GRAB   = 11'h040,
        NBF_SYNC   = 11'h080,
        NBF_RDATA  = 11'h100,
        NBF_RELEASE = 11'h200,
        NBF_ABORT  = 11'h400
    } nbf_state_t;
endpackage : nbf_pkg

// File: hdl/nbf_busy_timer.sv
// Purpose: counts down an internal program or erase operation
// Assumes: start is a one-cycle pulse, kill is the init level
// Notes: only nrst or kill stops a running count; bus aborts never reach it
`timescale 1ns/1ns
`default_nettype none
module nbf_busy_timer #(
    parameter int WIDTH = 21
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic kill,
    input wire logic start,
    input wire logic [WIDTH-1:0] load,
    // status
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge mclk) begin
        if (!nrst || kill) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start && !busy) begin
            count <= load;
            busy <= 1'b1;
            done <= 1'b0;
        end else if (busy) begin
            count <= count - 1'b1;
            if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule : nbf_busy_timer
`default_nettype wire

// File: hdl/nbf_status_byte.sv
// Purpose: forms the byte returned on a read, with polling bits
// Assumes: busy comes from the operation timer, erasing from the command decode
// Notes: toggle flips once per completed read while busy
`timescale 1ns/1ns
`default_nettype none
module nbf_status_byte (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // operation state
    input wire logic busy,
    input wire logic erasing,
    input wire logic [7:0] last_data,
    input wire logic read_done,
    // stored data
    input wire logic [7:0] stored,
    // result
    output logic [7:0] read_byte
);
    logic toggle;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            toggle <= 1'b0;
        end else if (busy && read_done) begin
            toggle <= ~toggle;
        end
    end

    // polling bits replace bits 7 and 6 of the byte while an operation runs
    always_comb begin
        if (busy) begin
            read_byte = stored;
            read_byte[7] = erasing ? 1'b0 : ~last_data[7];
            read_byte[6] = toggle;
        end else begin
            read_byte = stored;
        end
    end
endmodule : nbf_status_byte
`default_nettype wire

// File: bench/nbf_host.sv
// Purpose: host model that runs cycles on the nibble bus
// Assumes: drives at rising edges, device outputs registered
// Notes: released lines show the inverse of their last level
`timescale 1ns/1ns
`default_nettype none
module nbf_host
    import nbf_pkg::*;
(
    // clock
    input wire logic mclk,
    // device side
    input wire logic [3:0] dev_out,
    input wire logic dev_oe,
    // host side
    output logic frame_strobe_n,
    output wire logic [3:0] nibble_bus_in
);
    logic drv = 1'b0;
    logic [3:0] hv = 4'hF;
    logic [3:0] last = 4'hF;
    // a floating bus must not read back as the last driven value
    assign nibble_bus_in = drv ? hv : (dev_oe ? dev_out : ~last);
    always @(posedge mclk) last <= nibble_bus_in;
    initial frame_strobe_n = 1'b1;

    task automatic xfer(input logic [3:0] st, input logic [3:0] sel, input logic [27:0] a,
                        input logic [7:0] d, input logic [3:0] sz, input int stop, output logic [24:0] obs);
        logic [3:0] q [16];
        int n;
        q[0] = st;
        q[1] = sel;
        for (int i = 0; i < 7; i++) q[2 + i] = a[4 * (6 - i) +: 4];
        q[9] = sz;
        n = 10;
        if (st == START_WRITE) begin
            q[10] = d[3:0];
            q[11] = d[7:4];
            n = 12;
        end
        q[n] = TURN_NIBBLE;
        n++;
        // strobe again mid-cycle, then the abort nibble
        if (stop > 0) begin
            q[stop] = 4'h3;
            q[stop + 1] = ABORT_NIBBLE;
            n = stop + 2;
        end
        obs = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            drv <= 1'b1;
            hv <= q[i];
            frame_strobe_n <= (i == 0 || i == stop) ? 1'b0 : 1'b1;
        end
        @(posedge mclk);
        drv <= 1'b0;
        frame_strobe_n <= 1'b1;
        @(posedge mclk);
        for (int k = 0; k < 5; k++) begin
            #1;
            obs = {obs[19:0], dev_oe ? {1'b1, dev_out} : 5'h00};
            @(posedge mclk);
        end
    endtask : xfer
endmodule : nbf_host
`default_nettype wire

// File: bench/nibble_bus_flash_target_test.sv
// Purpose: self-checking bench for the nibble bus flash target
// Assumes: short program and erase counts for simulation
// Notes: address bits that the target ignores carry random noise
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module nibble_bus_flash_target_test
    import nbf_pkg::*;
;
    localparam int PLOAD = 60;
    localparam int ELOAD = 300;
    // identity codes are arbitrary values handed to the target
    localparam logic [7:0] ID_MAKER = 8'h3C;
    localparam logic [7:0] ID_PART = 8'hC3;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic init_n = 1'b1;
    logic [3:0] straps = 4'h0;
    wire strobe_n;
    wire [3:0] bus_in;
    logic [3:0] bus_out;
    logic bus_oe;
    logic op_busy;
    logic reg_access;
    int mismatches = 0;
    int compares = 0;
    int seed = 13;
    int oe_hits = 0;
    int reg_hits = 0;
    logic [24:0] obs;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] d;

    nbf_target #(.PROGRAM_LOAD(PLOAD), .ERASE_LOAD(ELOAD), .MAKER_CODE(ID_MAKER), .PART_CODE(ID_PART))
        i_dut (.mclk(mclk), .nrst(nrst), .init_n(init_n),
        .frame_strobe_n(strobe_n), .nibble_bus_in(bus_in), .nibble_bus_out(bus_out), .nibble_bus_oe(bus_oe),
        .select_strap_pins(straps), .op_busy(op_busy), .reg_access(reg_access));
    nbf_host i_host (.mclk(mclk), .dev_out(bus_out), .dev_oe(bus_oe), .frame_strobe_n(strobe_n),
        .nibble_bus_in(bus_in));

    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        oe_hits <= oe_hits + (bus_oe === 1'b1);
        reg_hits <= reg_hits + (reg_access === 1'b1);
    end

    function automatic logic [27:0] arr(input logic [15:0] a);
        return {5'($random(seed)), 1'b1, 2'($random(seed)), 4'h0, a};
    endfunction : arr

    task automatic rd(input logic [27:0] a, output logic [7:0] b);
        i_host.xfer(START_READ, straps, a, 8'h00, SIZE_ONE_BYTE, 0, obs);
        b = {obs[13:10], obs[18:15]};
        `CHK("read frame", {5'h10, 2'b11, 5'h1F, 5'h00}, {obs[24:19], obs[14], obs[9:0]})
    endtask : rd
    task automatic wr(input logic [27:0] a, input logic [7:0] dv);
        i_host.xfer(START_WRITE, straps, a, dv, SIZE_ONE_BYTE, 0, obs);
        `CHK("write frame", {5'h10, 5'h1F, 15'h0}, obs)
    endtask : wr
    task automatic unlock(input logic [7:0] cmd);
        wr(arr(UNLOCK_ADDR_A), UNLOCK_DATA_A);
        wr(arr(UNLOCK_ADDR_B), UNLOCK_DATA_B);
        wr(arr(UNLOCK_ADDR_A), cmd);
    endtask : unlock
    task automatic wait_idle;
        for (int i = 0; i < ELOAD + 100 && op_busy !== 1'b0; i++) @(posedge mclk);
    endtask : wait_idle
    task automatic close_out;
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        close_out();
    end

    initial begin
        straps = 4'($random(seed));
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("oe after reset", 1'b0, bus_oe)
        for (int s = 0; s < 16; s++) begin
            if (s != START_READ && s != START_WRITE) begin
                i_host.xfer(4'(s), straps, arr(16'h0), 8'h00, SIZE_ONE_BYTE, 0, obs);
            end
        end
        i_host.xfer(START_READ, ~straps, arr(16'h0), 8'h00, SIZE_ONE_BYTE, 0, obs);
        // any other size nibble is refused
        i_host.xfer(START_READ, straps, arr(16'h0), 8'h00, 4'($random(seed)) | 4'h1, 0, obs);
        `CHK("refused cycles drive", 0, oe_hits)
        unlock(CMD_ERASE_SETUP);
        unlock(CMD_SECTOR_ERASE);
        rd(arr(16'h0), b0);
        rd(arr(16'h0), b1);
        `CHK("erase poll bit7", 2'b00, {b0[7], b1[7]})
        `CHK("erase toggle", 1'b1, b0[6] ^ b1[6])
        i_host.xfer(START_READ, straps, arr(16'h0), 8'h00, SIZE_ONE_BYTE, 5, obs);
        `CHK("abort release", 25'h0, obs)
        `CHK("busy after abort", 1'b1, op_busy)
        wait_idle();
        rd(arr(16'h0012), b0);
        `CHK("erased byte", ERASED_BYTE, b0)
        for (int n = 0; n < 6; n++) begin
            d = 8'($random(seed));
            unlock(CMD_PROGRAM);
            wr(arr({8'h00, 8'(n * 37 + 1)}), d);
            rd(arr({8'h00, 8'(n * 37 + 1)}), b0);
            rd(arr({8'h00, 8'(n * 37 + 1)}), b1);
            `CHK("program poll bit7", {~d[7], ~d[7]}, {b0[7], b1[7]})
            `CHK("program toggle", 1'b1, b0[6] ^ b1[6])
            wait_idle();
            rd(arr({8'h00, 8'(n * 37 + 1)}), b0);
            `CHK("programmed byte", d, b0)
        end
        rd(28'h0000123, b0);
        `CHK("register read", 8'h00, b0)
        `CHK("register pulses", 1, reg_hits)
        unlock(CMD_ERASE_SETUP);
        unlock(CMD_CHIP_ERASE);
        repeat (4) @(posedge mclk);
        `CHK("chip erase ignored", 1'b0, op_busy)
        unlock(CMD_ID_ENTRY);
        rd(arr(16'h0), b0);
        rd(arr(16'h1), b1);
        `CHK("id codes", {ID_MAKER, ID_PART}, {b0, b1})
        unlock(CMD_ID_EXIT);
        // init pin stops a running program
        unlock(CMD_PROGRAM);
        wr(arr(16'h0077), 8'h00);
        init_n <= 1'b0;
        repeat (2) @(posedge mclk);
        init_n <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("init stops program", 2'b00, {op_busy, bus_oe})
        close_out();
    end
endmodule : nibble_bus_flash_target_test
`default_nettype wire
